//--- core/dpalu_pkg.sv
// package for the data-processing execute unit
package dpalu_pkg;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned RESET_FLAGS  = 4'h0;
    localparam logic [3:0]  PC_REG_NUM   = 4'hF;
    localparam logic [31:0] PC_OFS_IMM   = 32'h0000_0008;
    localparam logic [31:0] PC_OFS_REG   = 32'h0000_000C;
    localparam int unsigned BIT_IMM_SEL  = 25;
    localparam int unsigned BIT_FLAG_UPD = 20;
    localparam int unsigned BIT_REG_SHFT = 4;
    localparam int unsigned BIT_MUL_MARK = 7;
    localparam int unsigned EXEC_LATENCY = 1;

    typedef enum logic [3:0] {
        DP_AND  = 4'h0, DP_EOR = 4'h1, DP_SUB = 4'h2, DP_RSB = 4'h3,
        DP_ADD  = 4'h4, DP_ADC = 4'h5, DP_SBC = 4'h6, DP_RSC = 4'h7,
        DP_TST  = 4'h8, DP_TEQ = 4'h9, DP_CMP = 4'hA, DP_CMN = 4'hB,
        DP_ORR  = 4'hC, DP_MOV = 4'hD, DP_BIC = 4'hE, DP_MVN = 4'hF
    } dpalu_op_t;

    typedef enum logic [1:0] {
        SH_LSL = 2'h0, SH_LSR = 2'h1, SH_ASR = 2'h2, SH_ROR = 2'h3
    } dpalu_shift_t;
endpackage : dpalu_pkg

//--- core/dpalu_shifter.sv
// barrel shifter producing the second operand and shifter carry
`timescale 1ns/10ps
`default_nettype none
module dpalu_shifter
    import dpalu_pkg::*;
(
    input  wire logic [31:0] value_in,      // register operand
    input  wire logic [1:0]  kind_in,       // shift type
    input  wire logic [7:0]  amount_in,     // shift amount
    input  wire logic        by_reg_in,     // amount came from a register
    input  wire logic        carry_in,      // current carry flag
    output logic      [31:0] result_out,    // shifted value
    output logic             carry_out      // shifter carry
);
    logic [63:0] wide;
    logic [4:0]  amt5;

    always_comb begin
        result_out = value_in;
        carry_out  = carry_in;
        amt5       = amount_in[4:0];
        wide       = 64'h0;
        if (!by_reg_in && amount_in == 8'h00) begin
            // instruction encoded zero amounts mean special forms
            unique case (kind_in)
                SH_LSL: begin
                    result_out = value_in;
                    carry_out  = carry_in;
                end
                SH_LSR: begin
                    result_out = 32'h0;
                    carry_out  = value_in[31];
                end
                SH_ASR: begin
                    result_out = {32{value_in[31]}};
                    carry_out  = value_in[31];
                end
                SH_ROR: begin
                    result_out = {carry_in, value_in[31:1]};
                    carry_out  = value_in[0];
                end
            endcase
        end else if (amount_in == 8'h00) begin
            result_out = value_in;
            carry_out  = carry_in;
        end else if (amount_in < 8'h20) begin
            unique case (kind_in)
                SH_LSL: begin
                    wide       = {32'h0, value_in} << amt5;
                    result_out = wide[31:0];
                    carry_out  = wide[32];
                end
                SH_LSR: begin
                    wide       = {value_in, 32'h0} >> amt5;
                    result_out = wide[63:32];
                    carry_out  = wide[31];
                end
                SH_ASR: begin
                    wide       = 64'($signed({value_in, 32'h0}) >>> amt5);
                    result_out = wide[63:32];
                    carry_out  = wide[31];
                end
                SH_ROR: begin
                    wide       = {value_in, value_in} >> amt5;
                    result_out = wide[31:0];
                    carry_out  = wide[31];
                end
            endcase
        end else begin
            unique case (kind_in)
                SH_LSL: begin
                    result_out = 32'h0;
                    carry_out  = (amount_in == 8'h20) ? value_in[0] : 1'b0;
                end
                SH_LSR: begin
                    result_out = 32'h0;
                    carry_out  = (amount_in == 8'h20) ? value_in[31] : 1'b0;
                end
                SH_ASR: begin
                    result_out = {32{value_in[31]}};
                    carry_out  = value_in[31];
                end
                SH_ROR: begin
                    // n-32 repeated reduces to the low five bits; zero means 32
                    wide       = {value_in, value_in} >> amt5;
                    result_out = wide[31:0];
                    carry_out  = wide[31];
                end
            endcase
        end
    end
endmodule : dpalu_shifter
`default_nettype wire

//--- core/dpalu_core.sv
// data-processing execute unit: decode, operand two, alu, flags
// ****************************************
// Operation
// - sixteen operations decoded from the 4-bit opcode in code order
// - test and compare ops never write destination, always update flags
// - first operand from register; immediate bit picks shifted register or immediate
// - flag-update bit 20 clear keeps flags, set updates them
// - logical ops: overflow kept, carry from shifter, zero and negative from result
// - arithmetic ops: overflow signed, carry from alu bit 31, zero, negative
// - carry forms add carry; subtract forms add carry minus one; reverse swaps
// - move returns operand two, move inverted its complement
// - encoded shift amount is five bits with a two-bit type
// - left shift fills zeros, last discarded bit is shifter carry
// - encoded left shift by zero passes operand and old carry
// - encoded right shift by zero means shift by 32
// - encoded arithmetic shift zero means 32, all bits sign
// - encoded rotate zero means one-bit rotate through carry
// - register shift uses lowest byte; program counter not allowed there
// - register amount zero passes operand and old carry; 1..31 as encoded
// - register logical shift 32 and beyond: zero result, defined carry
// - register arithmetic shift 32 or more fills with sign bit
// - register rotate 32 keeps operand, carry bit 31; beyond reduces
// - register shift needs bit 7 zero, else not data processing
// - immediate is zero-extended byte rotated right by twice rotate field
// - destination pc without flag update writes pc, status unchanged
// - destination pc with flag update writes pc, restores saved status
// - pc operand is address plus 8, or plus 12 with register shift
// - execute only when condition field is satisfied by flags
// ****************************************
`timescale 1ns/10ps
`default_nettype none
module dpalu_core
    import dpalu_pkg::*;
(
    input  wire logic        clk_in,                  // core clock, 125 MHz
    input  wire logic        srst_in,                 // sync reset, active high
    input  wire logic        issue_in,                // instruction valid this cycle
    input  wire logic [31:0] instr_in,                // instruction word
    input  wire logic [31:0] instr_addr_in,           // address of the instruction
    input  wire logic [31:0] first_operand_reg_in,    // first operand register value
    input  wire logic [31:0] second_operand_reg_in,   // second operand register value
    input  wire logic [31:0] shift_amount_reg_in,     // shift amount register value
    input  wire logic [3:0]  current_status_word_in,  // N Z C V flags now
    input  wire logic [31:0] saved_status_word_in,    // saved status of current mode
    output logic             not_dp_out,              // word is multiply or undefined
    output logic             result_valid_out,        // commit strobe, one cycle
    output logic [31:0]      result_out,              // value for destination
    output logic [3:0]       dest_reg_out,            // destination register number
    output logic             dest_write_out,          // write destination
    output logic             pc_write_out,            // destination is program counter
    output logic             status_write_out,        // write status flags
    output logic [3:0]       next_flags_out,          // new N Z C V
    output logic             status_restore_out       // copy saved status word to status
);
    // ****************************************
    // decode
    // ****************************************
    dpalu_op_t   op;
    logic        imm_sel;
    logic        flag_upd;
    logic        reg_shift;
    logic [3:0]  cond;
    logic [3:0]  rn_num;
    logic [3:0]  rd_num;
    logic [3:0]  rm_num;
    logic        fn, fz, fc, fv;
    logic        cond_ok;
    logic        is_test;
    logic        is_logic;
    logic        bad_word;

    assign op        = dpalu_op_t'(instr_in[24:21]);
    assign imm_sel   = instr_in[BIT_IMM_SEL];
    assign flag_upd  = instr_in[BIT_FLAG_UPD];
    assign reg_shift = !imm_sel && instr_in[BIT_REG_SHFT];
    assign cond      = instr_in[31:28];
    assign rn_num    = instr_in[19:16];
    assign rd_num    = instr_in[15:12];
    assign rm_num    = instr_in[3:0];
    assign {fn, fz, fc, fv} = current_status_word_in;
    assign is_test   = (op[3:2] == 2'b10);
    assign is_logic  = (op inside {DP_AND, DP_EOR, DP_TST, DP_TEQ, DP_ORR, DP_MOV, DP_BIC, DP_MVN});
    // bit 7 set on a register shift, or pc as shift register, is not ours
    assign bad_word  = reg_shift && (instr_in[BIT_MUL_MARK] || instr_in[11:8] == PC_REG_NUM);
    assign not_dp_out = issue_in && bad_word;

    // judged on the flags as presented this cycle
    always_comb begin
        unique case (cond)
            4'h0: cond_ok = fz;
            4'h1: cond_ok = !fz;
            4'h2: cond_ok = fc;
            4'h3: cond_ok = !fc;
            4'h4: cond_ok = fn;
            4'h5: cond_ok = !fn;
            4'h6: cond_ok = fv;
            4'h7: cond_ok = !fv;
            4'h8: cond_ok = fc && !fz;
            4'h9: cond_ok = !fc || fz;
            4'hA: cond_ok = (fn == fv);
            4'hB: cond_ok = (fn != fv);
            4'hC: cond_ok = !fz && (fn == fv);
            4'hD: cond_ok = fz || (fn != fv);
            4'hE: cond_ok = 1'b1;
            4'hF: cond_ok = 1'b0; // reserved code never executes
        endcase
    end

    // ****************************************
    // operands
    // ****************************************
    logic [31:0] pc_value;
    logic [31:0] op1;
    logic [31:0] rm_val;
    logic [31:0] sh_res;
    logic        sh_carry;
    logic [31:0] imm_rot;
    logic        imm_carry;
    logic [31:0] op2;
    logic        op2_carry;
    logic [7:0]  sh_amount;

    // pc reads ahead by the prefetch depth
    assign pc_value = instr_addr_in + (reg_shift ? PC_OFS_REG : PC_OFS_IMM);
    assign op1      = (rn_num == PC_REG_NUM) ? pc_value : first_operand_reg_in;
    assign rm_val   = (rm_num == PC_REG_NUM) ? pc_value : second_operand_reg_in;
    assign sh_amount = reg_shift ? shift_amount_reg_in[7:0] : {3'h0, instr_in[11:7]};

    dpalu_shifter u_shifter (
        .value_in   (rm_val),
        .kind_in    (instr_in[6:5]),
        .amount_in  (sh_amount),
        .by_reg_in  (reg_shift),
        .carry_in   (fc),
        .result_out (sh_res),
        .carry_out  (sh_carry)
    );

    always_comb begin
        logic [63:0] dbl;
        logic [4:0]  rot;
        rot       = {instr_in[11:8], 1'b0};
        dbl       = {24'h0, instr_in[7:0], 24'h0, instr_in[7:0]} >> rot;
        imm_rot   = dbl[31:0];
        // zero rotate leaves carry as it was
        imm_carry = (rot == 5'd0) ? fc : imm_rot[31];
    end

    // immediate path bypasses the shifter entirely
    assign op2       = imm_sel ? imm_rot : sh_res;
    assign op2_carry = imm_sel ? imm_carry : sh_carry;

    // ****************************************
    // alu
    // ****************************************
    logic [31:0] alu_res;
    logic [32:0] sum;
    logic [31:0] add_a;
    logic [31:0] add_b;
    logic        add_cin;
    logic        alu_c;
    logic        alu_v;

    // one adder serves every arithmetic op; subtract is a plus not b plus one
    always_comb begin
        add_a   = op1;
        add_b   = op2;
        add_cin = 1'b0;
        unique case (op)
            DP_SUB, DP_CMP: begin
                add_b   = ~op2;
                add_cin = 1'b1;
            end
            DP_RSB: begin
                add_a   = op2;
                add_b   = ~op1;
                add_cin = 1'b1;
            end
            DP_ADC: add_cin = fc;
            DP_SBC: begin
                add_b   = ~op2;
                add_cin = fc;
            end
            DP_RSC: begin
                add_a   = op2;
                add_b   = ~op1;
                add_cin = fc;
            end
            default: add_cin = 1'b0;
        endcase
        sum   = {1'b0, add_a} + {1'b0, add_b} + {32'h0, add_cin};
        alu_c = sum[32];
        alu_v = (add_a[31] == add_b[31]) && (sum[31] != add_a[31]);
    end

    always_comb begin
        unique case (op)
            DP_AND, DP_TST: alu_res = op1 & op2;
            DP_EOR, DP_TEQ: alu_res = op1 ^ op2;
            DP_ORR:         alu_res = op1 | op2;
            DP_MOV:         alu_res = op2;
            DP_BIC:         alu_res = op1 & ~op2;
            DP_MVN:         alu_res = ~op2;
            default:        alu_res = sum[31:0];
        endcase
    end

    // ****************************************
    // commit stage
    // ****************************************
    logic        valid_q,   next_valid;
    logic [31:0] result_q,  next_result;
    logic [3:0]  dest_q,    next_dest;
    logic        dwr_q,     next_dwr;
    logic        pcwr_q,    next_pcwr;
    logic        swr_q,     next_swr;
    logic [3:0]  flags_q,   next_flags;
    logic        restore_q, next_restore;
    logic        exec;
    logic        to_pc;

    assign exec  = issue_in && cond_ok && !bad_word;
    // test forms never redirect the program counter
    assign to_pc = (rd_num == PC_REG_NUM) && !is_test;

    always_comb begin
        next_valid   = exec;
        next_result  = alu_res;
        next_dest    = rd_num;
        next_dwr     = exec && !is_test;
        next_pcwr    = exec && to_pc;
        next_swr     = 1'b0;
        next_restore = 1'b0;
        next_flags   = current_status_word_in;
        // saved flags win over result flags here
        if (exec && to_pc) begin
            next_restore = flag_upd;
            next_swr     = flag_upd;
            if (flag_upd) begin
                next_flags = saved_status_word_in[31:28];
            end
        end else if (exec && (flag_upd || is_test)) begin
            next_swr = 1'b1;
            if (is_logic) begin
                next_flags = {alu_res[31], alu_res == 32'h0, op2_carry, fv};
            end else begin
                next_flags = {alu_res[31], alu_res == 32'h0, alu_c, alu_v};
            end
        end
    end

    // one stage for all, so nothing commits half an instruction
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            valid_q   <= 1'b0;
            result_q  <= 32'h0;
            dest_q    <= 4'h0;
            dwr_q     <= 1'b0;
            pcwr_q    <= 1'b0;
            swr_q     <= 1'b0;
            flags_q   <= 4'(RESET_FLAGS);
            restore_q <= 1'b0;
        end else begin
            valid_q   <= next_valid;
            result_q  <= next_result;
            dest_q    <= next_dest;
            dwr_q     <= next_dwr;
            pcwr_q    <= next_pcwr;
            swr_q     <= next_swr;
            flags_q   <= next_flags;
            restore_q <= next_restore;
        end
    end

    assign result_valid_out   = valid_q;
    assign result_out         = result_q;
    assign dest_reg_out       = dest_q;
    assign dest_write_out     = dwr_q;
    assign pc_write_out       = pcwr_q;
    assign status_write_out   = swr_q;
    assign next_flags_out     = flags_q;
    assign status_restore_out = restore_q;

    // ****************************************
    // checks
    // ****************************************
    test_no_write_a: assert property (@(posedge clk_in) disable iff (srst_in)
        issue_in && is_test |=> !dest_write_out)
        else $error("test op wrote destination");

    test_flags_a: assert property (@(posedge clk_in) disable iff (srst_in)
        exec && is_test |=> status_write_out)
        else $error("test op skipped flags");

    flags_kept_a: assert property (@(posedge clk_in) disable iff (srst_in)
        issue_in && !flag_upd && !is_test |=> !status_write_out)
        else $error("flags written without update bit");

    logic_v_a: assert property (@(posedge clk_in) disable iff (srst_in)
        exec && is_logic && !to_pc |=> next_flags_out[0] == $past(fv))
        else $error("logical op changed overflow");

    zero_flag_a: assert property (@(posedge clk_in) disable iff (srst_in)
        exec && (flag_upd || is_test) && !to_pc |=> next_flags_out[2] == (result_out == 32'h0))
        else $error("zero flag mismatch");

    cond_fail_a: assert property (@(posedge clk_in) disable iff (srst_in)
        issue_in && !cond_ok |=> !result_valid_out && !dest_write_out && !status_write_out)
        else $error("failed condition had effect");

    pc_plain_a: assert property (@(posedge clk_in) disable iff (srst_in)
        exec && to_pc && !flag_upd |=> pc_write_out && !status_write_out)
        else $error("pc write touched status");

    pc_restore_a: assert property (@(posedge clk_in) disable iff (srst_in)
        exec && to_pc && flag_upd |=> status_restore_out && pc_write_out)
        else $error("pc write missed restore");

    mul_mark_a: assert property (@(posedge clk_in) disable iff (srst_in)
        issue_in && reg_shift && instr_in[7] |-> not_dp_out ##1 !result_valid_out)
        else $error("bit 7 word executed");

    mov_value_a: assert property (@(posedge clk_in) disable iff (srst_in)
        exec && op == DP_MVN |=> result_out == ~$past(op2))
        else $error("move inverted wrong");

    logic_c_a: assert property (@(posedge clk_in) disable iff (srst_in)
        exec && is_logic && flag_upd && !to_pc |=> next_flags_out[1] == $past(op2_carry))
        else $error("logical carry not from shifter");

    commit_pair_a: assert property (@(posedge clk_in) disable iff (srst_in)
        dest_write_out || status_write_out || pc_write_out |-> result_valid_out)
        else $error("write without commit strobe");

    cover_test_c:    cover property (@(posedge clk_in) exec && is_test);
    cover_restore_c: cover property (@(posedge clk_in) exec && to_pc && flag_upd);
    cover_regsh_c:   cover property (@(posedge clk_in) exec && reg_shift && shift_amount_reg_in[7:0] > 8'h20);
    cover_skip_c:    cover property (@(posedge clk_in) issue_in && !cond_ok);
    cover_ror_c:     cover property (@(posedge clk_in) exec && !imm_sel && instr_in[6:5] == 2'h3);
endmodule : dpalu_core
`default_nettype wire

//--- verif/dpalu_regfile_model.sv
// register file and status word model facing the execute unit
`timescale 1ns/10ps
`default_nettype none
module dpalu_regfile_model
    import dpalu_pkg::*;
(
    input  wire logic        clk_in,     // core clock
    input  wire logic        srst_in,    // sync reset, active high
    input  wire logic [31:0] instr_in,   // word being issued
    input  wire logic        valid_in,   // commit strobe
    input  wire logic [31:0] result_in,  // value to commit
    input  wire logic [3:0]  dest_in,    // register to write
    input  wire logic        dest_wr_in, // register write enable
    input  wire logic        flag_wr_in, // flag write enable
    input  wire logic [3:0]  flags_in,   // new n z c v
    input  wire logic        restore_in, // saved word to status
    output logic      [31:0] op1_out,    // first operand value
    output logic      [31:0] op2_out,    // second operand value
    output logic      [31:0] shamt_out,  // shift amount register value
    output logic      [3:0]  status_out, // current n z c v
    output logic      [31:0] saved_out   // saved status word
);
    logic [31:0] regs [16];
    logic [3:0]  flags;
    logic [31:0] saved;

    // reads are combinational so operands belong to the issue edge
    assign op1_out    = regs[instr_in[19:16]];
    assign op2_out    = regs[instr_in[3:0]];
    assign shamt_out  = regs[instr_in[11:8]];
    assign status_out = flags;
    assign saved_out  = saved;

    // register, pc and flags all land on the one commit edge
    always @(posedge clk_in) begin
        if (srst_in) begin
            flags <= 4'h0;
        end else if (valid_in) begin
            if (dest_wr_in) begin
                regs[dest_in] <= result_in;
            end
            if (restore_in) begin
                flags <= saved[31:28];
            end else if (flag_wr_in) begin
                flags <= flags_in;
            end
        end
    end
endmodule : dpalu_regfile_model
`default_nettype wire

//--- verif/data_processing_alu_shifter_tb.sv
// self-checking bench for the data-processing execute unit
`timescale 1ns/10ps
`default_nettype none
module data_processing_alu_shifter_tb;
    import dpalu_pkg::*;
    localparam logic hi = 1'h1;
    localparam logic lo = 1'h0;
    localparam logic dc = 1'hx;
    logic        clk_in = 1'h0;
    logic        srst_in = 1'h1;
    logic        issue_in = 1'h0;
    logic [31:0] instr_in = 32'h0;
    logic [31:0] addr = 32'h0000_0100;
    logic [31:0] op1, op2, sam, sav, res;
    logic [3:0]  cur, drg, nfl;
    logic        ndp, vld, dwr, pcw, swr, rso, g_pc, g_rs;
    int          n_fail = 0;
    int          checks = 0;

    always #4 clk_in = ~clk_in;

    dpalu_core dut (.clk_in(clk_in), .srst_in(srst_in), .issue_in(issue_in), .instr_in(instr_in),
        .instr_addr_in(addr), .first_operand_reg_in(op1), .second_operand_reg_in(op2),
        .shift_amount_reg_in(sam), .current_status_word_in(cur), .saved_status_word_in(sav),
        .not_dp_out(ndp), .result_valid_out(vld), .result_out(res), .dest_reg_out(drg),
        .dest_write_out(dwr), .pc_write_out(pcw), .status_write_out(swr), .next_flags_out(nfl),
        .status_restore_out(rso));

    dpalu_regfile_model rf (.clk_in(clk_in), .srst_in(srst_in), .instr_in(instr_in), .valid_in(vld),
        .result_in(res), .dest_in(drg), .dest_wr_in(dwr), .flag_wr_in(swr), .flags_in(nfl),
        .restore_in(rso), .op1_out(op1), .op2_out(op2), .shamt_out(sam), .status_out(cur),
        .saved_out(sav));

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_flag(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t flags %h expected %h", $time, got, exp);
        end
    endtask : chk_flag

    function automatic logic [31:0] dp(input logic [3:0] op, input logic i, s,
                                       input logic [3:0] rn, rd, input logic [11:0] o2);
        return {4'hE, 2'h0, i, op, s, rn, rd, o2};
    endfunction : dp

    // one issue, check the commit cycle, then let the model commit
    task automatic exec(input logic [31:0] w, input logic nd, v, dw, sw,
                        input logic [31:0] r, input logic [3:0] f);
        issue_in <= 1'h1;
        instr_in <= w;
        #1 chk_val(ndp, nd);
        @(posedge clk_in);
        issue_in <= 1'h0;
        #1 chk_val(vld, v);
        chk_val(dwr, dw);
        if (sw !== dc) chk_val(swr, sw);
        if (dw) chk_val(res, r);
        if (dw) chk_val(drg, w[15:12]);
        if (sw !== lo) chk_flag(nfl, f);
        g_pc = pcw;
        g_rs = rso;
        @(posedge clk_in);
    endtask : exec

    task automatic ok(input logic [31:0] w, input logic dw, sw, input logic [31:0] r, input logic [3:0] f);
        exec(w, lo, hi, dw, sw, r, f);
    endtask : ok

    task automatic setf(input logic [3:0] f);
        @(posedge clk_in);
        rf.flags <= f;
    endtask : setf

    task automatic t_ops();
        logic [31:0] er [16] = '{32'h1, 32'hFFFF_FFFE, 32'hFFFF_FFFE, 32'h2, 32'h0, 32'h0, 32'hFFFF_FFFD,
            32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'h8000_0001, 32'h7FFF_FFFE, 32'h7FFF_FFFE};
        logic [3:0]  ef [4] = '{4'h0, 4'h8, 4'h9, 4'h6};
        logic        t;
        setf(4'h0);
        for (int k = 0; k < 16; k++) begin
            t = (k[3:2] == 2'h2);
            ok(dp(k[3:0], lo, t, 4'h4, 4'h5, 12'h001), !t, t, er[k], ef[k[1:0]]);
        end
        $display("ops done");
    endtask : t_ops

    task automatic t_flags();
        setf(4'h0);
        ok(dp(4'h4, hi, hi, 4'h4, 4'h5, 12'h001), hi, hi, 32'h8000_0000, 4'h9);
        setf(4'h2);
        ok(dp(4'h5, hi, hi, 4'h3, 4'h5, 12'h000), hi, hi, 32'h0, 4'h6);
        ok(dp(4'h6, hi, hi, 4'h0, 4'h5, 12'h000), hi, hi, 32'h0, 4'h6);
        ok(dp(4'h7, hi, hi, 4'h1, 4'h5, 12'h001), hi, hi, 32'h8000_0000, 4'h9);
        setf(4'h1);
        ok(dp(4'h0, lo, hi, 4'h3, 4'h5, 12'h000), hi, hi, 32'h0, 4'h5);
        ok(dp(4'h4, hi, lo, 4'h4, 4'h5, 12'h001), hi, lo, 32'h8000_0000, 4'h0);
        $display("flags done");
    endtask : t_flags

    task automatic t_shift();
        setf(4'h0);
        ok(dp(4'hD, lo, hi, 4'h0, 4'h5, 12'h081), hi, hi, 32'h2, 4'h2);
        ok(dp(4'hD, lo, hi, 4'h0, 4'h5, 12'hF81), hi, hi, 32'h8000_0000, 4'h8);
        ok(dp(4'hD, lo, hi, 4'h0, 4'h5, 12'h021), hi, hi, 32'h0, 4'h6);
        ok(dp(4'hD, lo, hi, 4'h0, 4'h5, 12'h0C1), hi, hi, 32'hC000_0000, 4'hA);
        ok(dp(4'hD, lo, hi, 4'h0, 4'h5, 12'h041), hi, hi, 32'hFFFF_FFFF, 4'hA);
        ok(dp(4'hD, lo, hi, 4'h0, 4'h5, 12'h061), hi, hi, 32'hC000_0000, 4'hA);
        ok(dp(4'hD, lo, hi, 4'h0, 4'h5, 12'h0E1), hi, hi, 32'hC000_0000, 4'hA);
        ok(dp(4'hD, lo, hi, 4'h0, 4'h5, 12'h261), hi, hi, 32'h1800_0000, 4'h0);
        ok(dp(4'hD, hi, hi, 4'h0, 4'h5, 12'h4FF), hi, hi, 32'hFF00_0000, 4'hA);
        $display("shift done");
    endtask : t_shift

    task automatic t_regshift();
        logic [31:0] sa [9] = '{32'h100, 32'h20, 32'h21, 32'h20, 32'h28, 32'h32, 32'h20, 32'h24, 32'h1};
        logic [1:0]  ty [9] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3, 2'h1};
        logic [31:0] er [9] = '{32'h8000_0001, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'h8000_0001,
            32'h1800_0000, 32'h4000_0000};
        logic [3:0]  ef [9] = '{4'hA, 4'h6, 4'h4, 4'h6, 4'h4, 4'hA, 4'hA, 4'h0, 4'h2};
        setf(4'h2);
        for (int k = 0; k < 9; k++) begin
            @(posedge clk_in);
            rf.regs[2] <= sa[k];
            ok(dp(4'hD, lo, hi, 4'h0, 4'h5, {4'h2, 1'h0, ty[k], 5'h11}), hi, hi, er[k], ef[k]);
        end
        ok(dp(4'h4, lo, lo, 4'hF, 4'h5, 12'h000), hi, lo, 32'h108, 4'h0);
        ok(dp(4'h4, lo, lo, 4'hF, 4'h5, 12'h010), hi, lo, 32'h10C, 4'h0);
        exec(dp(4'hD, lo, hi, 4'h0, 4'h5, 12'h291), hi, lo, lo, lo, 32'h0, 4'h0);
        exec(dp(4'hD, lo, hi, 4'h0, 4'h5, 12'hF11), hi, lo, lo, lo, 32'h0, 4'h0);
        $display("register shift done");
    endtask : t_regshift

    task automatic t_pc();
        setf(4'h0);
        ok(dp(4'hD, lo, lo, 4'h0, 4'hF, 12'h001), hi, lo, 32'h8000_0001, 4'h0);
        chk_val({g_pc, g_rs}, 32'h2);
        ok(dp(4'hD, lo, hi, 4'h0, 4'hF, 12'h001), hi, hi, 32'h8000_0001, 4'h5);
        chk_val({g_pc, g_rs}, 32'h3);
        ok(dp(4'hA, hi, hi, 4'h0, 4'hF, 12'h000), lo, hi, 32'h0, 4'h6);
        chk_val(g_pc, 32'h0);
        // xor with the always code plants another condition field
        exec(dp(4'hD, hi, lo, 4'h0, 4'h5, 12'h007) ^ 32'hF000_0000, lo, lo, lo, lo, 32'h0, 4'h0);
        exec(dp(4'hD, hi, lo, 4'h0, 4'h5, 12'h007) ^ 32'h1000_0000, lo, lo, lo, lo, 32'h0, 4'h0);
        ok(dp(4'hD, hi, lo, 4'h0, 4'h5, 12'h007) ^ 32'hE000_0000, hi, lo, 32'h7, 4'h0);
        $display("pc and condition done");
    endtask : t_pc

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // watchdog: a hang counts as a mismatch
    initial begin
        #100000;
        n_fail++;
        results();
    end

    initial begin
        rf.regs[0] = 32'h0;
        rf.regs[1] = 32'h8000_0001;
        rf.regs[2] = 32'h0;
        rf.regs[3] = 32'hFFFF_FFFF;
        rf.regs[4] = 32'h7FFF_FFFF;
        rf.saved = 32'h5000_0000;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'h0;
        t_ops();
        t_flags();
        t_shift();
        t_regshift();
        t_pc();
        results();
    end
endmodule : data_processing_alu_shifter_tb
`default_nettype wire
